// ==== shared/bsse_pkg.sv ====
// Shared types and constants for the branch, skip and shift execution block.
package bsse_pkg;

  // Instruction classes handled by this block.
  typedef enum logic [5:0] {
    compare_with_carry_op, compare_immediate_op,
    skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op, skip_io_bit_set_op,
    branch_flag_set_op, branch_flag_clear_op, branch_equal_op, branch_not_equal_op,
    branch_carry_set_op, branch_carry_clear_op, branch_same_higher_op, branch_lower_op,
    branch_negative_op, branch_positive_op, branch_signed_ge_op, branch_signed_less_op,
    branch_halfcarry_set_op, branch_halfcarry_clear_op, branch_copy_set_op, branch_copy_clear_op,
    branch_overflow_set_op, branch_overflow_clear_op, branch_irq_enabled_op, branch_irq_disabled_op,
    io_bit_set_op, io_bit_clear_op, shift_left_logical_op, shift_right_logical_op,
    rotate_left_carry_op, rotate_right_carry_op, shift_right_arith_op, idle_op
  } bsse_op_type;

  // Bit positions in the status_register.
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // Cycle counts and program counter steps.
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam int PC_STEP = 1;
  localparam int PC_SKIP_ONE = 2;
  localparam int PC_SKIP_TWO = 3;
  localparam int OFFSET_W = 7;

  typedef struct packed {
    bsse_op_type op;
    logic [7:0] rd_val;
    logic [7:0] rr_val;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [5:0] io_addr;
    logic signed [6:0] offset;
    logic next_two_word;
  } bsse_req_type;

  typedef struct packed {
    logic h;
    logic v;
    logic n;
    logic z;
    logic c;
  } bsse_flags_type;

  function automatic logic is_branch(bsse_op_type op);
    return op inside {[branch_flag_set_op:branch_irq_disabled_op]};
  endfunction

  function automatic logic is_skip(bsse_op_type op);
    return op inside {[skip_reg_bit_clear_op:skip_io_bit_set_op]};
  endfunction

endpackage

// ==== design/bsse_alu.sv ====
// Compare and shift datapath with flag generation.
`timescale 1ns/1ns
module bsse_alu (
  // Operation and operands.
  input wire bsse_pkg::bsse_op_type op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  // Result.
  output logic [7:0] result,
  output bsse_pkg::bsse_flags_type flags
);
  wire is_cmp = (op == bsse_pkg::compare_with_carry_op) || (op == bsse_pkg::compare_immediate_op);
  wire borrow_in = (op == bsse_pkg::compare_with_carry_op) && carry_in;
  wire [8:0] diff = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
  wire [4:0] low_diff = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
  wire cmp_v = (a[7] & ~b[7] & ~diff[7]) | (~a[7] & b[7] & diff[7]);

  logic [7:0] shifted;
  logic shift_c;

  always_comb begin
    shifted = a;
    shift_c = 1'b0;
    case (op)
      bsse_pkg::shift_left_logical_op: begin
        shifted = {a[6:0], 1'b0};
        shift_c = a[7];
      end
      bsse_pkg::shift_right_logical_op: begin
        shifted = {1'b0, a[7:1]};
        shift_c = a[0];
      end
      bsse_pkg::rotate_left_carry_op: begin
        shifted = {a[6:0], carry_in};
        shift_c = a[7];
      end
      bsse_pkg::rotate_right_carry_op: begin
        shifted = {carry_in, a[7:1]};
        shift_c = a[0];
      end
      bsse_pkg::shift_right_arith_op: begin
        shifted = {a[7], a[7:1]};
        shift_c = a[0];
      end
      default: begin
        shifted = a;
        shift_c = 1'b0;
      end
    endcase
  end

  assign result = is_cmp ? diff[7:0] : shifted;
  assign flags.c = is_cmp ? diff[8] : shift_c;
  assign flags.z = (result == 8'h00);
  assign flags.n = result[7];
  assign flags.v = is_cmp ? cmp_v : (result[7] ^ shift_c);
  assign flags.h = low_diff[4];
endmodule

// ==== design/bsse_cond.sv ====
// Branch and skip condition evaluation.
`timescale 1ns/1ns
module bsse_cond (
  // Operation and the values it tests.
  input wire bsse_pkg::bsse_op_type op,
  input wire logic [7:0] status,
  input wire logic [2:0] flag_sel,
  input wire logic tested_bit,
  // Condition met.
  output logic hit
);
  wire c = status[bsse_pkg::FLAG_C];
  wire z = status[bsse_pkg::FLAG_Z];
  wire n = status[bsse_pkg::FLAG_N];
  wire v = status[bsse_pkg::FLAG_V];

  always_comb begin
    case (op)
      bsse_pkg::skip_reg_bit_clear_op, bsse_pkg::skip_io_bit_clear_op: hit = ~tested_bit;
      bsse_pkg::skip_reg_bit_set_op, bsse_pkg::skip_io_bit_set_op: hit = tested_bit;
      bsse_pkg::branch_flag_set_op: hit = status[flag_sel];
      bsse_pkg::branch_flag_clear_op: hit = ~status[flag_sel];
      bsse_pkg::branch_equal_op: hit = z;
      bsse_pkg::branch_not_equal_op: hit = ~z;
      bsse_pkg::branch_carry_set_op, bsse_pkg::branch_lower_op: hit = c;
      bsse_pkg::branch_carry_clear_op, bsse_pkg::branch_same_higher_op: hit = ~c;
      bsse_pkg::branch_negative_op: hit = n;
      bsse_pkg::branch_positive_op: hit = ~n;
      bsse_pkg::branch_signed_ge_op: hit = ~(n ^ v);
      bsse_pkg::branch_signed_less_op: hit = n ^ v;
      bsse_pkg::branch_halfcarry_set_op: hit = status[bsse_pkg::FLAG_H];
      bsse_pkg::branch_halfcarry_clear_op: hit = ~status[bsse_pkg::FLAG_H];
      bsse_pkg::branch_copy_set_op: hit = status[bsse_pkg::FLAG_T];
      bsse_pkg::branch_copy_clear_op: hit = ~status[bsse_pkg::FLAG_T];
      bsse_pkg::branch_overflow_set_op: hit = v;
      bsse_pkg::branch_overflow_clear_op: hit = ~v;
      bsse_pkg::branch_irq_enabled_op: hit = status[bsse_pkg::FLAG_I];
      bsse_pkg::branch_irq_disabled_op: hit = ~status[bsse_pkg::FLAG_I];
      default: hit = 1'b0;
    endcase
  end
endmodule

// ==== design/bsse_exec.sv ====
// Execution unit for compares, skips, flag branches, I/O bit writes and shifts.
`timescale 1ns/1ns
module bsse_exec #(
  parameter int PC_W = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_n,
  // Instruction request.
  input wire logic req_valid,
  input wire bsse_pkg::bsse_req_type req,
  input wire logic [PC_W-1:0] pc_in,
  input wire logic [7:0] status_in,
  output logic req_ready,
  // I/O space read port.
  output logic [5:0] io_rd_addr,
  input wire logic [7:0] io_rd_data,
  // Completion and write-back.
  output logic done,
  output logic pc_load,
  output logic [PC_W-1:0] pc_next,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  output logic status_wr,
  output logic [7:0] status_wr_data,
  output logic io_wr,
  output logic [5:0] io_wr_addr,
  output logic [7:0] io_wr_data
);
  typedef enum logic {st_idle, st_busy} bsse_state_type;

  bsse_state_type state;
  logic [1:0] cnt;
  logic reg_pend;
  logic status_pend;
  logic io_pend;
  bsse_pkg::bsse_op_type cur_op;

  // Request decode.
  wire accept = req_valid && req_ready;
  bsse_pkg::bsse_op_type op;
  assign op = req.op;
  wire is_branch = bsse_pkg::is_branch(op);
  wire is_skip = bsse_pkg::is_skip(op);
  wire is_io_skip = (op == bsse_pkg::skip_io_bit_clear_op) || (op == bsse_pkg::skip_io_bit_set_op);
  wire is_cmp = (op == bsse_pkg::compare_with_carry_op) || (op == bsse_pkg::compare_immediate_op);
  wire is_shift = op inside {[bsse_pkg::shift_left_logical_op:bsse_pkg::shift_right_arith_op]};
  wire is_io_bit = (op == bsse_pkg::io_bit_set_op) || (op == bsse_pkg::io_bit_clear_op);

  assign req_ready = (state == st_idle);
  assign io_rd_addr = req.io_addr;

  // The tested bit comes from the working register or from the addressed I/O register.
  wire tested_bit = is_io_skip ? io_rd_data[req.bit_sel] : req.rd_val[req.bit_sel];

  logic hit;
  bsse_cond u_cond (
    .op(op),
    .status(status_in),
    .flag_sel(req.bit_sel),
    .tested_bit(tested_bit),
    .hit(hit)
  );

  // Compares take the second register or the immediate; shifts use only the first operand.
  wire [7:0] alu_b = (op == bsse_pkg::compare_immediate_op) ? req.imm : req.rr_val;
  logic [7:0] alu_result;
  bsse_pkg::bsse_flags_type alu_flags;
  bsse_alu u_alu (
    .op(op),
    .a(req.rd_val),
    .b(alu_b),
    .carry_in(status_in[bsse_pkg::FLAG_C]),
    .result(alu_result),
    .flags(alu_flags)
  );

  // Merged status value: compares also touch half-carry, shifts do not.
  logic [7:0] next_status;
  always_comb begin
    next_status = status_in;
    next_status[bsse_pkg::FLAG_C] = alu_flags.c;
    next_status[bsse_pkg::FLAG_Z] = alu_flags.z;
    next_status[bsse_pkg::FLAG_N] = alu_flags.n;
    next_status[bsse_pkg::FLAG_V] = alu_flags.v;
    if (is_cmp) begin
      next_status[bsse_pkg::FLAG_H] = alu_flags.h;
    end
  end

  // Program counter targets; the offset is sign extended.
  wire [PC_W-1:0] offset_ext = {{(PC_W-bsse_pkg::OFFSET_W){req.offset[6]}}, req.offset};
  wire [PC_W-1:0] pc_seq = PC_W'(pc_in + bsse_pkg::PC_STEP);
  wire [PC_W-1:0] pc_branch = PC_W'(pc_in + offset_ext + bsse_pkg::PC_STEP);
  wire [PC_W-1:0] pc_skip = req.next_two_word ? PC_W'(pc_in + bsse_pkg::PC_SKIP_TWO)
                                              : PC_W'(pc_in + bsse_pkg::PC_SKIP_ONE);
  logic [PC_W-1:0] next_pc;
  always_comb begin
    if (is_branch && hit) begin
      next_pc = pc_branch;
    end else if (is_skip && hit) begin
      next_pc = pc_skip;
    end else begin
      next_pc = pc_seq;
    end
  end

  // Cycle count of the accepted instruction.
  logic [1:0] next_cycles;
  always_comb begin
    if (is_io_bit) begin
      next_cycles = bsse_pkg::CYC_TWO;
    end else if (is_branch && hit) begin
      next_cycles = bsse_pkg::CYC_TWO;
    end else if (is_skip && hit) begin
      next_cycles = req.next_two_word ? bsse_pkg::CYC_THREE : bsse_pkg::CYC_TWO;
    end else begin
      next_cycles = bsse_pkg::CYC_ONE;
    end
  end

  // I/O read-modify-write value for the single-bit writes.
  logic [7:0] next_io;
  always_comb begin
    next_io = io_rd_data;
    next_io[req.bit_sel] = (op == bsse_pkg::io_bit_set_op);
  end

  // Sequencer: results are captured at acceptance and released with done.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      cnt <= 2'h0;
      done <= 1'b0;
    end else if (accept) begin
      done <= (next_cycles == bsse_pkg::CYC_ONE);
      cnt <= next_cycles - bsse_pkg::CYC_ONE;
      state <= (next_cycles == bsse_pkg::CYC_ONE) ? st_idle : st_busy;
    end else if (state == st_busy) begin
      done <= (cnt == bsse_pkg::CYC_ONE);
      cnt <= cnt - bsse_pkg::CYC_ONE;
      state <= (cnt == bsse_pkg::CYC_ONE) ? st_idle : st_busy;
    end else begin
      done <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_pend <= 1'b0;
      status_pend <= 1'b0;
      io_pend <= 1'b0;
      cur_op <= bsse_pkg::idle_op;
    end else if (accept) begin
      reg_pend <= is_shift;
      status_pend <= is_cmp || is_shift;
      io_pend <= is_io_bit;
      cur_op <= op;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_next <= '0;
      reg_wr_data <= 8'h00;
      status_wr_data <= 8'h00;
      io_wr_addr <= 6'h00;
      io_wr_data <= 8'h00;
    end else if (accept) begin
      pc_next <= next_pc;
      reg_wr_data <= alu_result;
      status_wr_data <= next_status;
      io_wr_addr <= req.io_addr;
      io_wr_data <= next_io;
    end
  end

  assign pc_load = done;
  assign reg_wr = done && reg_pend;
  assign status_wr = done && status_pend;
  assign io_wr = done && io_pend;

  // Checks.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  sequence one_wait_then_done;
    !done ##1 done;
  endsequence

  sequence two_waits_then_done;
    !done ##1 !done ##1 done;
  endsequence

  cmp_single_cycle_a: assert property (accept && is_cmp |=> done && status_wr && !reg_wr)
    else $error("compare did not finish in one cycle with flag write");

  cmp_borrow_flag_a: assert property (accept && op == bsse_pkg::compare_immediate_op
      |=> status_wr_data[bsse_pkg::FLAG_C] == ($past(req.rd_val) < $past(req.imm)))
    else $error("compare immediate carry wrong");

  reg_skip_miss_a: assert property (accept && is_skip && !is_io_skip && !hit
      |=> done && pc_next == PC_W'($past(pc_in) + 1))
    else $error("register skip without match did not step once");

  skip_long_a: assert property (accept && is_skip && hit && req.next_two_word
      |=> two_waits_then_done ##0 pc_next == PC_W'($past(pc_in, 3) + 3))
    else $error("skip over two-word instruction mistimed");

  io_skip_short_a: assert property (accept && is_io_skip && hit && !req.next_two_word
      |=> one_wait_then_done ##0 pc_next == PC_W'($past(pc_in, 2) + 2))
    else $error("I/O skip over one-word instruction mistimed");

  branch_taken_a: assert property (accept && is_branch && hit
      |=> one_wait_then_done ##0 !status_wr && !reg_wr)
    else $error("taken branch not two cycles or changed flags");

  equal_branch_a: assert property (accept && op == bsse_pkg::branch_equal_op && !status_in[bsse_pkg::FLAG_Z]
      |=> done && pc_next == PC_W'($past(pc_in) + 1))
    else $error("equal branch taken without zero flag");

  signed_ge_a: assert property (accept && op == bsse_pkg::branch_signed_ge_op
      && (status_in[bsse_pkg::FLAG_N] == status_in[bsse_pkg::FLAG_V]) |=> !done)
    else $error("signed greater-or-equal not taken");

  io_set_write_a: assert property (accept && op == bsse_pkg::io_bit_set_op
      |=> one_wait_then_done ##0 io_wr && !status_wr && io_wr_data[$past(req.bit_sel, 2)])
    else $error("I/O bit set did not write a one after two cycles");

  left_shift_a: assert property (accept && op == bsse_pkg::shift_left_logical_op
      |=> reg_wr && reg_wr_data == {$past(req.rd_val[6:0]), 1'b0}
      && status_wr_data[bsse_pkg::FLAG_C] == $past(req.rd_val[7]))
    else $error("logical left shift wrong");

  right_shift_a: assert property (accept && op == bsse_pkg::shift_right_logical_op
      |=> reg_wr_data == {1'b0, $past(req.rd_val[7:1])})
    else $error("logical right shift wrong");

  rotate_carry_a: assert property (accept && op == bsse_pkg::rotate_right_carry_op
      |=> reg_wr_data[7] == $past(status_in[bsse_pkg::FLAG_C])
      && status_wr_data[bsse_pkg::FLAG_C] == $past(req.rd_val[0]))
    else $error("rotate right through carry wrong");

  arith_sign_a: assert property (accept && op == bsse_pkg::shift_right_arith_op
      |=> reg_wr_data == {$past(req.rd_val[7]), $past(req.rd_val[7:1])}
      && status_wr_data[bsse_pkg::FLAG_C] == $past(req.rd_val[0]))
    else $error("arithmetic right shift wrong");

  cwc_carry_a: assert property (accept && op == bsse_pkg::compare_with_carry_op
      |=> status_wr_data[bsse_pkg::FLAG_C] == ({1'b0, $past(req.rd_val)}
      < {1'b0, $past(req.rr_val)} + {8'h00, $past(status_in[bsse_pkg::FLAG_C])}))
    else $error("compare with carry borrow wrong");

  cpi_zero_a: assert property (accept && op == bsse_pkg::compare_immediate_op
      |=> status_wr_data[bsse_pkg::FLAG_Z] == ($past(req.rd_val) == $past(req.imm)))
    else $error("compare immediate zero flag wrong");

  skip_miss_quiet_a: assert property (accept && is_skip && !hit
      |=> done && !status_wr && !reg_wr && !io_wr)
    else $error("unmatched skip mistimed or wrote state");

  reg_skip_short_a: assert property (accept && is_skip && !is_io_skip && hit && !req.next_two_word
      |=> one_wait_then_done ##0 pc_next == PC_W'($past(pc_in, 2) + 2))
    else $error("register skip over one word mistimed");

  io_skip_miss_a: assert property (accept && is_io_skip && !hit
      |=> done && pc_next == PC_W'($past(pc_in) + 1))
    else $error("unmatched I/O skip did not step once");

  branch_miss_a: assert property (accept && is_branch && !hit
      |=> done && !status_wr && pc_next == PC_W'($past(pc_in) + 1))
    else $error("untaken branch mistimed or wrote flags");

  not_equal_a: assert property (accept && op == bsse_pkg::branch_not_equal_op
      && !status_in[bsse_pkg::FLAG_Z]
      |=> one_wait_then_done ##0 pc_next == PC_W'($signed({1'b0, $past(pc_in, 2)}) + $past(req.offset, 2) + 1))
    else $error("not-equal branch target wrong");

  carry_set_a: assert property (accept && status_in[bsse_pkg::FLAG_C]
      && (op == bsse_pkg::branch_carry_set_op || op == bsse_pkg::branch_lower_op) |=> !done)
    else $error("carry set branch not taken");

  same_higher_a: assert property (accept && status_in[bsse_pkg::FLAG_C]
      && op == bsse_pkg::branch_same_higher_op |=> done)
    else $error("same-or-higher branch taken");

  positive_a: assert property (accept && !status_in[bsse_pkg::FLAG_N]
      && op == bsse_pkg::branch_positive_op |=> !done)
    else $error("plus branch not taken");

  signed_less_a: assert property (accept && op == bsse_pkg::branch_signed_less_op
      && (status_in[bsse_pkg::FLAG_N] == status_in[bsse_pkg::FLAG_V]) |=> done)
    else $error("signed less-than branch taken");

  halfcarry_clear_a: assert property (accept && status_in[bsse_pkg::FLAG_H]
      && op == bsse_pkg::branch_halfcarry_clear_op |=> done)
    else $error("half-carry cleared branch taken");

  copy_set_a: assert property (accept && status_in[bsse_pkg::FLAG_T]
      && op == bsse_pkg::branch_copy_set_op |=> !done)
    else $error("copy flag branch not taken");

  overflow_clear_a: assert property (accept && !status_in[bsse_pkg::FLAG_V]
      && op == bsse_pkg::branch_overflow_clear_op |=> !done)
    else $error("overflow cleared branch not taken");

  irq_disabled_a: assert property (accept && status_in[bsse_pkg::FLAG_I]
      && op == bsse_pkg::branch_irq_disabled_op |=> done)
    else $error("interrupt disabled branch taken");

  io_clear_write_a: assert property (accept && op == bsse_pkg::io_bit_clear_op
      |=> one_wait_then_done ##0 io_wr && !status_wr && !io_wr_data[$past(req.bit_sel, 2)])
    else $error("I/O bit clear did not write a zero");

  io_write_kind_a: assert property (io_wr
      |-> cur_op == bsse_pkg::io_bit_set_op || cur_op == bsse_pkg::io_bit_clear_op)
    else $error("I/O write from a wrong instruction");

  reg_write_kind_a: assert property (reg_wr
      |-> cur_op inside {[bsse_pkg::shift_left_logical_op:bsse_pkg::shift_right_arith_op]})
    else $error("register write from a non-shift");

  rotate_left_a: assert property (accept && op == bsse_pkg::rotate_left_carry_op
      |=> reg_wr_data == {$past(req.rd_val[6:0]), $past(status_in[bsse_pkg::FLAG_C])}
      && status_wr_data[bsse_pkg::FLAG_C] == $past(req.rd_val[7]))
    else $error("rotate left through carry wrong");

  shift_flags_a: assert property (accept && is_shift
      |=> status_wr_data[bsse_pkg::FLAG_V] == (reg_wr_data[7] ^ status_wr_data[bsse_pkg::FLAG_C])
      && status_wr_data[bsse_pkg::FLAG_Z] == (reg_wr_data == 8'h00)
      && status_wr_data[bsse_pkg::FLAG_H] == $past(status_in[bsse_pkg::FLAG_H]))
    else $error("shift flags wrong");

  right_shift_carry_a: assert property (accept && op == bsse_pkg::shift_right_logical_op
      |=> status_wr_data[bsse_pkg::FLAG_C] == $past(req.rd_val[0]) && !status_wr_data[bsse_pkg::FLAG_N])
    else $error("logical right shift carry wrong");

  done_pulse_a: assert property (done && !accept |=> !done)
    else $error("done stood over one cycle");

endmodule

// ==== verification/branch_skip_shift_exec_test.sv ====
// Self-checking bench for the branch, skip and shift execution unit.
`timescale 1ns/1ns
module branch_skip_shift_exec_test;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  bsse_pkg::bsse_req_type req = '0;
  logic [15:0] pc_in = 16'h0100;
  logic [7:0] status_in = 8'h00;
  logic [7:0] io_rd_data = 8'h00;
  logic req_ready, done, pc_load, reg_wr, status_wr, io_wr;
  logic [15:0] pc_next;
  logic [7:0] reg_wr_data, status_wr_data, io_wr_data;
  logic [5:0] io_rd_addr, io_wr_addr;
  logic [7:0] va [4] = '{8'h00, 8'h10, 8'h80, 8'h00};
  logic [7:0] vb [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
  logic [7:0] vs [4] = '{8'h81, 8'h40, 8'h01, 8'h00};
  logic [7:0] vst [4] = '{8'h00, 8'hFF, 8'h55, 8'hAA};
  int n_fail = 0;
  int comparisons = 0;
  int cyc;

  always #10 sys_clk = ~sys_clk;

  bsse_exec #(.PC_W(16)) i_bsse_exec (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req), .pc_in(pc_in),
    .status_in(status_in), .req_ready(req_ready), .io_rd_addr(io_rd_addr), .io_rd_data(io_rd_data),
    .done(done), .pc_load(pc_load), .pc_next(pc_next), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
    .status_wr(status_wr), .status_wr_data(status_wr_data), .io_wr(io_wr), .io_wr_addr(io_wr_addr),
    .io_wr_data(io_wr_data)
  );

  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", name, e, g);
      n_fail++;
    end
  endtask

  // Issues one instruction at a falling edge and counts cycles until done; valid drops after the first cycle unless done has already come.
  task automatic go(input bsse_pkg::bsse_op_type op, input logic [7:0] a, input logic [7:0] b,
                    input logic [2:0] s, input logic signed [6:0] k, input logic tw, input logic [7:0] st);
    req.op = op;
    req.rd_val = a;
    req.rr_val = b;
    req.imm = b;
    req.bit_sel = s;
    req.io_addr = 6'h2A ^ {3'h0, s};
    req.offset = k;
    req.next_two_word = tw;
    status_in = st;
    io_rd_data = a;
    req_valid = 1'b1;
    chk("req_ready idle", 16'h0001, 16'(req_ready));
    chk("io_rd_addr", 16'(6'h2A ^ {3'h0, s}), 16'(io_rd_addr));
    @(posedge sys_clk);
    cyc = 0;
    do begin
      @(negedge sys_clk);
      cyc++;
      if (done !== 1'b1) begin
        req_valid = 1'b0;
        chk("req_ready busy", 16'h0000, 16'(req_ready));
      end
    end while (done !== 1'b1 && cyc < 4);
  endtask

  task automatic post(input int n, input logic [15:0] pc, input logic rw, input logic sw, input logic iw);
    chk("cycles", 16'(n), 16'(cyc));
    chk("pc_load", 16'h0001, 16'(pc_load));
    chk("pc_next", pc, pc_next);
    chk("reg_wr", 16'(rw), 16'(reg_wr));
    chk("status_wr", 16'(sw), 16'(status_wr));
    chk("io_wr", 16'(iw), 16'(io_wr));
  endtask

  function automatic logic [7:0] fsub(logic [7:0] a, logic [7:0] b, logic ci, logic [7:0] st);
    logic [8:0] r;
    logic [4:0] h;
    logic [7:0] o;
    r = {1'b0, a} - {1'b0, b} - 9'(ci);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(ci);
    o = st;
    o[0] = r[8];
    o[1] = (r[7:0] == 8'h00);
    o[2] = r[7];
    o[3] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
    o[5] = h[4];
    return o;
  endfunction

  function automatic logic [15:0] fsh(bsse_pkg::bsse_op_type op, logic [7:0] a, logic [7:0] st);
    logic [7:0] r;
    logic [7:0] o;
    logic c;
    case (op)
      bsse_pkg::shift_left_logical_op: {c, r} = {a, 1'b0};
      bsse_pkg::shift_right_logical_op: {r, c} = {1'b0, a};
      bsse_pkg::rotate_left_carry_op: {c, r} = {a, st[0]};
      bsse_pkg::rotate_right_carry_op: {r, c} = {st[0], a};
      default: {r, c} = {a[7], a};
    endcase
    o = st;
    o[0] = c;
    o[1] = (r == 8'h00);
    o[2] = r[7];
    o[3] = r[7] ^ c;
    return {r, o};
  endfunction

  function automatic logic fhit(bsse_pkg::bsse_op_type op, logic [7:0] st, logic [2:0] s);
    case (op)
      bsse_pkg::branch_flag_set_op: return st[s];
      bsse_pkg::branch_flag_clear_op: return !st[s];
      bsse_pkg::branch_equal_op: return st[1];
      bsse_pkg::branch_not_equal_op: return !st[1];
      bsse_pkg::branch_carry_set_op, bsse_pkg::branch_lower_op: return st[0];
      bsse_pkg::branch_carry_clear_op, bsse_pkg::branch_same_higher_op: return !st[0];
      bsse_pkg::branch_negative_op: return st[2];
      bsse_pkg::branch_positive_op: return !st[2];
      bsse_pkg::branch_signed_ge_op: return !(st[2] ^ st[3]);
      bsse_pkg::branch_signed_less_op: return st[2] ^ st[3];
      bsse_pkg::branch_halfcarry_set_op: return st[5];
      bsse_pkg::branch_halfcarry_clear_op: return !st[5];
      bsse_pkg::branch_copy_set_op: return st[6];
      bsse_pkg::branch_copy_clear_op: return !st[6];
      bsse_pkg::branch_overflow_set_op: return st[3];
      bsse_pkg::branch_overflow_clear_op: return !st[3];
      bsse_pkg::branch_irq_enabled_op: return st[7];
      bsse_pkg::branch_irq_disabled_op: return !st[7];
      default: return 1'b0;
    endcase
  endfunction

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    bsse_pkg::bsse_op_type op;
    logic [7:0] st;
    logic [7:0] e;
    logic [15:0] r;
    logic signed [6:0] k;
    logic t;
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk("done after reset", 16'h0000, 16'(done));
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 4; i++) begin
        for (int c = 0; c < 2; c++) begin
          op = j ? bsse_pkg::compare_with_carry_op : bsse_pkg::compare_immediate_op;
          st = 8'hD0 | 8'(c);
          go(op, va[i], vb[i], 3'h0, 7'h00, 1'b0, st);
          post(1, 16'h0101, 1'b0, 1'b1, 1'b0);
          chk("compare status", 16'(fsub(va[i], vb[i], 1'(j & c), st)), 16'(status_wr_data));
        end
      end
    end
    for (int o = int'(bsse_pkg::shift_left_logical_op); o <= int'(bsse_pkg::shift_right_arith_op); o++) begin
      for (int i = 0; i < 4; i++) begin
        for (int c = 0; c < 2; c++) begin
          op = bsse_pkg::bsse_op_type'(o);
          st = 8'hD0 | 8'(c);
          r = fsh(op, vs[i], st);
          go(op, vs[i], 8'h00, 3'h0, 7'h00, 1'b0, st);
          post(1, 16'h0101, 1'b1, 1'b1, 1'b0);
          chk("shift result", 16'(r[15:8]), 16'(reg_wr_data));
          chk("shift status", 16'(r[7:0]), 16'(status_wr_data));
        end
      end
    end
    for (int o = int'(bsse_pkg::branch_flag_set_op); o <= int'(bsse_pkg::branch_irq_disabled_op); o++) begin
      for (int i = 0; i < 4; i++) begin
        for (int s = 0; s < 8; s++) begin
          op = bsse_pkg::bsse_op_type'(o);
          k = s[0] ? 7'h40 : 7'h3F;
          t = fhit(op, vst[i], 3'(s));
          go(op, 8'h00, 8'h00, 3'(s), k, 1'b0, vst[i]);
          post(t ? 2 : 1, t ? 16'h0101 + {{9{k[6]}}, k} : 16'h0101, 1'b0, 1'b0, 1'b0);
        end
      end
    end
    for (int o = int'(bsse_pkg::skip_reg_bit_clear_op); o <= int'(bsse_pkg::skip_io_bit_set_op); o++) begin
      for (int s = 0; s < 8; s++) begin
        op = bsse_pkg::bsse_op_type'(o);
        t = ((8'hA5 >> s) & 8'h01) == 8'(o % 2);
        go(op, 8'hA5, 8'hA5, 3'(s), 7'h00, s[1], 8'hFF);
        post(t ? (s[1] ? 3 : 2) : 1, t ? (s[1] ? 16'h0103 : 16'h0102) : 16'h0101, 1'b0, 1'b0, 1'b0);
      end
    end
    for (int j = 0; j < 2; j++) begin
      for (int s = 0; s < 8; s++) begin
        op = j ? bsse_pkg::io_bit_clear_op : bsse_pkg::io_bit_set_op;
        e = 8'h5A;
        e[s] = (j == 0);
        go(op, 8'h5A, 8'h00, 3'(s), 7'h00, 1'b0, 8'hFF);
        post(2, 16'h0101, 1'b0, 1'b0, 1'b1);
        chk("io_wr_data", 16'(e), 16'(io_wr_data));
        chk("io_wr_addr", 16'(6'h2A ^ 6'(s)), 16'(io_wr_addr));
      end
    end
    go(bsse_pkg::idle_op, 8'h00, 8'h00, 3'h0, 7'h00, 1'b0, 8'h00);
    post(1, 16'h0101, 1'b0, 1'b0, 1'b0);
    final_report();
  end
endmodule
